/* src/fsd_pkg.sv */
/*
  shared constants, types and the protect decode of the flash sequencer.
  assumes a 100 MHz core clock and a mode-0 serial host.
*/
`default_nettype none
package fsd_pkg;
  // instruction codes
  localparam logic [7:0] FSD_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] FSD_PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] FSD_SECTOR_ERASE_CMD = 8'hD8;
  localparam logic [7:0] FSD_WHOLE_ARRAY_ERASE_CMD = 8'hC7;
  localparam logic [7:0] FSD_DEEP_POWERDOWN_CMD = 8'hB9;
  localparam logic [7:0] FSD_RELEASE_SIGNATURE_CMD = 8'hAB;
  // byte counts of a frame
  localparam logic [2:0] FSD_ADDR_DONE = 3'h4;
  localparam logic [2:0] FSD_OP_DONE = 3'h1;
  localparam logic [2:0] FSD_BYTE_SAT = 3'h7;
  // times in their own units, then cycles
  localparam int FSD_CLK_MHZ = 100;
  localparam int FSD_PROGRAM_CYCLE_TIME_US = 2000;
  localparam int FSD_SECTOR_ERASE_TIME_MS = 800;
  localparam int FSD_ARRAY_ERASE_TIME_MS = 7000;
  localparam int FSD_POWERDOWN_ENTRY_DELAY_US = 3;
  localparam int FSD_POWERDOWN_RELEASE_DELAY_US = 3;
  localparam int FSD_PROG_CYCLES = FSD_PROGRAM_CYCLE_TIME_US * FSD_CLK_MHZ;
  localparam int FSD_SE_CYCLES = FSD_SECTOR_ERASE_TIME_MS * 1000 * FSD_CLK_MHZ;
  localparam int FSD_BE_CYCLES = FSD_ARRAY_ERASE_TIME_MS * 1000 * FSD_CLK_MHZ;
  localparam int FSD_DP_CYCLES = FSD_POWERDOWN_ENTRY_DELAY_US * FSD_CLK_MHZ;
  localparam int FSD_RES_CYCLES = FSD_POWERDOWN_RELEASE_DELAY_US * FSD_CLK_MHZ;
  // reset values: {sck, cs_n, si} idle levels, latch and flags
  localparam logic [2:0] FSD_PIN_RST = 3'h2;
  localparam logic FSD_WEL_RST = 1'b0;
  localparam logic FSD_BUSY_RST = 1'b0;

  typedef enum logic [2:0] {
    FSD_CYC_IDLE = 3'b000,
    FSD_CYC_PROG_RD = 3'b001,
    FSD_CYC_PROG_WR = 3'b010,
    FSD_CYC_WAIT = 3'b011
  } fsd_cyc_t;

  typedef enum logic [1:0] {
    FSD_PWR_STBY = 2'b00,
    FSD_PWR_ENTER = 2'b01,
    FSD_PWR_DEEP = 2'b10,
    FSD_PWR_EXIT = 2'b11
  } fsd_pwr_t;

  // sector of eight covered by the protect bits; 4 and up cover all
  function automatic logic fsd_protected(input logic [2:0] bp, input logic [2:0] sec);
    case (bp)
      3'h0: fsd_protected = 1'b0;
      3'h1: fsd_protected = (sec == 3'h7);
      3'h2: fsd_protected = (sec[2:1] == 2'h3);
      3'h3: fsd_protected = sec[2];
      default: fsd_protected = 1'b1;
    endcase
  endfunction
endpackage
`default_nettype wire

/* src/fsd_pin_sync.sv */
/*
  three-stage synchroniser with agreement filter and edge pulses.
  assumes inputs are asynchronous pins; reset levels come from RST_VAL.
*/
`timescale 1ns/1ps
`default_nettype none
module fsd_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // pins
  input wire logic [W-1:0] din_i,
  // filtered level and edges
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 feeds s2 only; s2/s3 agreement rejects a half-caught change
  for (genvar g = 0; g < W; g++)
  begin : g_bit
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        s1[g] <= RST_VAL[g];
        s2[g] <= RST_VAL[g];
        s3[g] <= RST_VAL[g];
        lvl_o[g] <= RST_VAL[g];
        rise_o[g] <= 1'b0;
        fall_o[g] <= 1'b0;
      end
      else
      begin
        s1[g] <= din_i[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        rise_o[g] <= (s2[g] == s3[g]) && s3[g] && !lvl_o[g];
        fall_o[g] <= (s2[g] == s3[g]) && !s3[g] && lvl_o[g];
        if (s2[g] == s3[g])
        begin
          lvl_o[g] <= s3[g];
        end
      end
    end
  end
endmodule // fsd_pin_sync
`default_nettype wire

/* src/fsd_flash_seq.sv */
/*
  program, erase and deep power-down sequencer of a serial flash.
  assumes a mode-0 host on sck/cs_n/si, an array with combinational
  read on mem_addr_o, and status-write logic outside this block.
*/
// Summary of operation
// - program and erase need the write-enable latch, set by write-enable
// - programming only clears bits, never sets them
// - over 256 data bytes wrap inside the page; last 256 win
// - under 256 bytes program only addressed bytes of the page
// - program runs only when select rises on a byte boundary
// - valid program or erase starts timed cycle; busy high, latch cleared
// - program aimed at a protected page is discarded
// - sector erase: opcode and address; whole sector becomes FFh
// - sector erase runs only if select rises after third address byte
// - sector erase of a protected sector is not performed
// - whole-array erase is opcode alone and erases everything
// - whole-array erase only with all three protect bits zero
// - deep power-down after eighth opcode bit, entered after fixed delay
// - in deep power-down only release instruction is heard
// - deep power-down request during a busy cycle is rejected
// - power loss cancels deep power-down; power-up in standby
// - release: opcode, three dummy bytes, then signature on falling edges
// - further clocks repeat the signature byte
// - release during a busy cycle is not decoded
// - release leaves standby at once, or after delay from deep power-down
// - busy flag one while program, erase or status write runs
// - after power-up standby with write-enable latch clear
`timescale 1ns/1ps
`default_nettype none
module fsd_flash_seq
  import fsd_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter logic [7:0] SIGNATURE = 8'h5A, // arbitrary value
  parameter int PROG_CYCLES = FSD_PROG_CYCLES,
  parameter int SE_CYCLES = FSD_SE_CYCLES,
  parameter int BE_CYCLES = FSD_BE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // serial link
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  // status register neighbours
  input wire logic [2:0] protect_bits_i,
  input wire logic status_write_busy_i,
  input wire logic wel_clear_i,
  output logic write_enable_latch_o,
  output logic busy_flag_o,
  output logic deep_powerdown_o,
  // memory array
  input wire logic [7:0] mem_rdata_i,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_write_o,
  output logic mem_erase_sector_o,
  output logic mem_erase_all_o
);
  localparam int DP_DLY = FSD_DP_CYCLES;

  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [6:0] shreg;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic frame_ok;
  logic [7:0] page_buf [256];
  logic [255:0] page_mask;
  logic [7:0] page_ptr;
  fsd_cyc_t cyc;
  fsd_pwr_t pwr;
  logic [31:0] timer;
  logic [15:0] pwr_timer;
  logic [7:0] idx;

  fsd_pin_sync #(
    .W(3),
    .RST_VAL(FSD_PIN_RST)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .din_i({spi_sck_i, spi_cs_n_i, spi_si_i}),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // decoded link events
  logic cs_high;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] byte_in;
  logic byte_done;
  logic busy_any;
  logic write_enable_cmd_hit;
  logic at_ok;
  logic sec_prot;
  logic go_prog;
  logic go_se;
  logic go_be;
  logic go_dp;
  logic res_rel;
  assign cs_high = pin_lvl[1];
  assign cs_rise = pin_rise[1];
  assign cs_fall = pin_fall[1];
  assign sck_rise = pin_rise[2] && !cs_high;
  assign sck_fall = pin_fall[2] && !cs_high;
  assign byte_in = {shreg, pin_lvl[0]}; // msb first
  assign byte_done = sck_rise && (bit_cnt == 3'h7);
  assign busy_any = (cyc != FSD_CYC_IDLE) || status_write_busy_i;
  assign write_enable_cmd_hit = byte_done && (byte_cnt == 3'h0) && (byte_in == FSD_WRITE_ENABLE_CMD)
                    && !busy_any && (pwr == FSD_PWR_STBY);
  assign sec_prot = fsd_protected(protect_bits_i, addr[ADDR_W-1 -: 3]);
  // only a release on a byte boundary executes
  assign at_ok = cs_rise && frame_ok && (bit_cnt == 3'h0) && !busy_any;
  assign go_prog = at_ok && (opcode == FSD_PAGE_PROGRAM_CMD) && (byte_cnt > FSD_ADDR_DONE)
                   && write_enable_latch_o && !sec_prot;
  assign go_se = at_ok && (opcode == FSD_SECTOR_ERASE_CMD) && (byte_cnt == FSD_ADDR_DONE)
                 && write_enable_latch_o && !sec_prot;
  assign go_be = at_ok && (opcode == FSD_WHOLE_ARRAY_ERASE_CMD) && (byte_cnt == FSD_OP_DONE)
                 && write_enable_latch_o && (protect_bits_i == 3'h0);
  assign go_dp = at_ok && (opcode == FSD_DEEP_POWERDOWN_CMD) && (byte_cnt == FSD_OP_DONE);
  // release may end anywhere after the opcode
  assign res_rel = cs_rise && frame_ok && (opcode == FSD_RELEASE_SIGNATURE_CMD)
                   && (byte_cnt != 3'h0) && !busy_any;

  // bit and byte counting, opcode and address capture
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shreg <= 7'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
    end
    else if (cs_fall)
    begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
    end
    else if (sck_rise)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg <= byte_in[6:0];
      if (byte_done && (byte_cnt != FSD_BYTE_SAT))
      begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      if (byte_done && (byte_cnt == 3'h0))
      begin
        opcode <= byte_in;
      end
      else if (byte_done && (byte_cnt < FSD_ADDR_DONE))
      begin
        addr <= {addr[15:0], byte_in};
      end
    end
  end

  // frame admission: busy hides all, deep power-down all but release
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      frame_ok <= 1'b0;
    end
    else if (cs_fall)
    begin
      frame_ok <= 1'b0;
    end
    else if (byte_done && (byte_cnt == 3'h0))
    begin
      frame_ok <= !busy_any && ((pwr == FSD_PWR_STBY) || ((pwr == FSD_PWR_DEEP)
                  && (byte_in == FSD_RELEASE_SIGNATURE_CMD)));
    end
  end

  // page buffer data; no reset, only masked bytes are ever used
  always_ff @(posedge core_clk_i)
  begin
    if (byte_done && frame_ok && (opcode == FSD_PAGE_PROGRAM_CMD) && (byte_cnt >= FSD_ADDR_DONE))
    begin
      page_buf[page_ptr] <= byte_in; // wrap overwrites older bytes
    end
  end

  // which page bytes were addressed in this frame
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      page_mask <= '0;
      page_ptr <= 8'h00;
    end
    else if (byte_done && frame_ok && (opcode == FSD_PAGE_PROGRAM_CMD))
    begin
      if (byte_cnt == 3'h3)
      begin
        page_mask <= '0;
        page_ptr <= byte_in;
      end
      else if (byte_cnt >= FSD_ADDR_DONE)
      begin
        page_mask[page_ptr] <= 1'b1;
        page_ptr <= page_ptr + 8'h01; // stays in page
      end
    end
  end

  // write-enable latch; a set in the clear cycle wins
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      write_enable_latch_o <= FSD_WEL_RST;
    end
    else if (write_enable_cmd_hit)
    begin
      write_enable_latch_o <= 1'b1;
    end
    else if (go_prog || go_se || go_be || wel_clear_i)
    begin
      write_enable_latch_o <= 1'b0; // cleared at cycle start
    end
  end

  // self-timed program and erase cycle
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cyc <= FSD_CYC_IDLE;
      timer <= 32'h0;
      idx <= 8'h00;
      mem_addr_o <= '0;
      mem_wdata_o <= 8'h00;
      mem_write_o <= 1'b0;
      mem_erase_sector_o <= 1'b0;
      mem_erase_all_o <= 1'b0;
    end
    else
    begin
      mem_write_o <= 1'b0;
      mem_erase_sector_o <= 1'b0;
      mem_erase_all_o <= 1'b0;
      if (timer != 32'h0)
      begin
        timer <= timer - 32'h1;
      end
      case (cyc)
        FSD_CYC_IDLE:
        begin
          idx <= 8'h00;
          if (go_prog)
          begin
            cyc <= FSD_CYC_PROG_RD;
            timer <= 32'(PROG_CYCLES);
          end
          else if (go_se || go_be)
          begin
            cyc <= FSD_CYC_WAIT;
            timer <= go_se ? 32'(SE_CYCLES) : 32'(BE_CYCLES);
            mem_addr_o <= addr[ADDR_W-1:0]; // any byte picks its sector
            mem_erase_sector_o <= go_se;
            mem_erase_all_o <= go_be;
          end
        end
        FSD_CYC_PROG_RD:
        begin
          mem_addr_o <= {addr[ADDR_W-1:8], idx};
          if (page_mask[idx])
          begin
            cyc <= FSD_CYC_PROG_WR;
          end
          else if (idx == 8'hFF)
          begin
            cyc <= FSD_CYC_WAIT;
          end
          else
          begin
            idx <= idx + 8'h01;
          end
        end
        FSD_CYC_PROG_WR:
        begin
          mem_wdata_o <= mem_rdata_i & page_buf[idx]; // ones never return
          mem_write_o <= 1'b1;
          idx <= idx + 8'h01;
          cyc <= (idx == 8'hFF) ? FSD_CYC_WAIT : FSD_CYC_PROG_RD;
        end
        FSD_CYC_WAIT:
        begin
          if (timer == 32'h0)
          begin
            cyc <= FSD_CYC_IDLE;
          end
        end
        default:
        begin
          cyc <= FSD_CYC_IDLE;
        end
      endcase
    end
  end

  // busy flag, rises with the cycle state, falls one cycle after it
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      busy_flag_o <= FSD_BUSY_RST;
    end
    else
    begin
      busy_flag_o <= busy_any || go_prog || go_se || go_be;
    end
  end

  // power mode; reset stands for power-up
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pwr <= FSD_PWR_STBY;
      pwr_timer <= 16'h0;
      deep_powerdown_o <= 1'b0;
    end
    else
    begin
      if (pwr_timer != 16'h0)
      begin
        pwr_timer <= pwr_timer - 16'h1;
      end
      case (pwr)
        FSD_PWR_STBY:
        begin
          if (go_dp)
          begin
            pwr <= FSD_PWR_ENTER;
            pwr_timer <= 16'(FSD_DP_CYCLES - 1);
          end
        end
        FSD_PWR_ENTER:
        begin
          if (pwr_timer == 16'h0)
          begin
            pwr <= FSD_PWR_DEEP;
            deep_powerdown_o <= 1'b1;
          end
        end
        FSD_PWR_DEEP:
        begin
          if (res_rel)
          begin
            pwr <= FSD_PWR_EXIT; // delayed release
            pwr_timer <= 16'(FSD_RES_CYCLES - 1);
          end
        end
        FSD_PWR_EXIT:
        begin
          if (pwr_timer == 16'h0)
          begin
            pwr <= FSD_PWR_STBY;
            deep_powerdown_o <= 1'b0;
          end
        end
        default:
        begin
          pwr <= FSD_PWR_STBY;
        end
      endcase
    end
  end

  // signature shifter: bit 7 first, repeats every eight clocks
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      spi_so_o <= 1'b0;
      spi_so_oe_o <= 1'b0;
    end
    else if (cs_high)
    begin
      spi_so_oe_o <= 1'b0;
    end
    else if (sck_fall && frame_ok && (opcode == FSD_RELEASE_SIGNATURE_CMD) && (byte_cnt >= FSD_ADDR_DONE))
    begin
      spi_so_o <= SIGNATURE[~bit_cnt];
      spi_so_oe_o <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_enter_wait;
    !deep_powerdown_o ##DP_DLY deep_powerdown_o;
  endsequence
  sequence s_no_drive;
    !spi_so_oe_o [*8];
  endsequence

  wel_set_a: assert property (write_enable_cmd_hit |=> write_enable_latch_o)
    else $error("write-enable latch not set");
  prog_clear_a: assert property (mem_write_o |-> ((mem_wdata_o & ~$past(mem_rdata_i)) == 8'h00))
    else $error("program raised a bit");
  cycle_start_a: assert property ((go_prog || go_se || go_be) |=> busy_flag_o && !write_enable_latch_o)
    else $error("cycle start without busy or latch clear");
  prog_prot_a: assert property ((at_ok && (opcode == FSD_PAGE_PROGRAM_CMD) && sec_prot)
    |=> (cyc == FSD_CYC_IDLE))
    else $error("protected page programmed");
  se_frame_a: assert property ((cs_rise && (opcode == FSD_SECTOR_ERASE_CMD) && (byte_cnt != FSD_ADDR_DONE))
    |=> !mem_erase_sector_o)
    else $error("sector erase from a bad frame");
  bulk_prot_a: assert property (mem_erase_all_o |-> ($past(protect_bits_i) == 3'h0))
    else $error("whole erase while protected");
  dp_entry_a: assert property (go_dp |=> s_enter_wait)
    else $error("deep power-down entry timing");
  deep_ignore_a: assert property (deep_powerdown_o |-> !(go_prog || go_se || go_be || write_enable_cmd_hit))
    else $error("write instruction heard in deep power-down");
  dp_busy_a: assert property ((busy_any && cs_rise && (opcode == FSD_DEEP_POWERDOWN_CMD)) |=> $stable(pwr))
    else $error("deep power-down during busy cycle");
  res_busy_a: assert property ((busy_any && byte_done && (byte_cnt == 3'h0)
    && (byte_in == FSD_RELEASE_SIGNATURE_CMD)) |=> s_no_drive)
    else $error("release decoded while busy");
endmodule // fsd_flash_seq
`default_nettype wire

/* verification/fsd_host_model.sv */
/*
  host model of the serial link: sends frames of whole bytes, then an optional run of tail bits.
  assumes mode 0; sck idles low and stands still between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module fsd_host_model (
  // core clock, used only to start frames just after an edge
  input wire logic core_clk_i,
  // serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  // last sixteen bits seen on so
  output logic [15:0] rx_o
);
  // idle levels at time zero
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    rx_o = '0;
  end

  // select stays low for the whole frame; bytes go msb first, tail bits are ones
  task automatic frame(input logic [7:0] b[$], input int tail);
    int n;
    n = b.size() * 8 + tail;
    @(posedge core_clk_i) #1;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      si_o = (i / 8 < b.size()) ? b[i / 8][7 - i % 8] : 1'b1;
      #40 sck_o = 1'b1;
      // so moves late behind the synchroniser, so read it just before the fall
      #40 rx_o = {rx_o[14:0], so_i};
      sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~si_o; // released line has no pull: show the inverse
    #200;
  endtask
endmodule // fsd_host_model
`default_nettype wire

/* verification/fsd_flash_seq_tb_top.sv */
/*
  self-checking bench of the flash sequencer: host model on the link, array model on the memory port.
  assumes shortened program and erase counts; expectations are literal values written in the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module fsd_flash_seq_tb_top
  import fsd_pkg::*;
;
  localparam int PROG_N = 1000;
  localparam logic [7:0] SIG = 8'h5A; // arbitrary value
  logic core_clk, resetn, sck, cs_n, si, so, so_oe, sw_busy, wel_clear, write_enable_latch, busy, deep;
  logic wr, er_sec, er_all;
  logic [2:0] protect;
  logic [18:0] addr;
  logic [7:0] wdata, rdata, e;
  logic [15:0] rx;
  logic [7:0] mem [0:524287];
  logic [7:0] q[$];
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  // 100 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  fsd_host_model host (.core_clk_i(core_clk), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .rx_o(rx));

  fsd_flash_seq #(.SIGNATURE(SIG), .PROG_CYCLES(PROG_N), .SE_CYCLES(50), .BE_CYCLES(50)) dut (
    .core_clk_i(core_clk), .resetn_i(resetn), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_si_i(si),
    .spi_so_o(so), .spi_so_oe_o(so_oe), .protect_bits_i(protect), .status_write_busy_i(sw_busy),
    .wel_clear_i(wel_clear), .write_enable_latch_o(write_enable_latch), .busy_flag_o(busy), .deep_powerdown_o(deep),
    .mem_rdata_i(rdata), .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_write_o(wr),
    .mem_erase_sector_o(er_sec), .mem_erase_all_o(er_all));

  // array model: combinational read, pulses land at the edge
  assign rdata = mem[addr];
  always @(posedge core_clk)
  begin
    if (wr)
      mem[addr] <= wdata;
    if (er_sec)
      for (int i = 0; i < 65536; i++)
        mem[{addr[18:16], 16'(i)}] <= 8'hFF;
    if (er_all)
      foreach (mem[i])
        mem[i] <= 8'hFF;
  end

  // hang guard: the whole run needs well under this
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, n_fail);
  endtask

  // inputs move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic send(input logic [7:0] b[$], input int tail = 0);
    host.frame(b, tail);
    tick(10);
  endtask

  task automatic write_enable_cmd();
    send({FSD_WRITE_ENABLE_CMD});
    chk("latch set", 1'b1, write_enable_latch);
  endtask

  // bounded wait for the timed cycle to end
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000)
    begin
      tick(1);
      k++;
    end
    chk("busy at end", 1'b0, busy);
  endtask

  initial
  begin
    resetn = 1'b0;
    sw_busy = 1'b0;
    wel_clear = 1'b0;
    protect = 3'h0;
    foreach (mem[i])
      mem[i] = 8'hFF;
    tick(20);
    resetn = 1'b1;
    tick(2);
    chk("latch after reset", 1'b0, write_enable_latch);
    chk("deep after reset", 1'b0, deep);
    send({FSD_PAGE_PROGRAM_CMD, 8'h00, 8'h00, 8'h10, 8'h00});
    chk("busy without latch", 1'b0, busy);
    done("no latch");

    mem[19'h11] = 8'h3C;
    write_enable_cmd();
    send({FSD_PAGE_PROGRAM_CMD, 8'h00, 8'h00, 8'h10, 8'hA5, 8'h0F, 8'hF0});
    chk("busy program", 1'b1, busy);
    chk("latch program", 1'b0, write_enable_latch);
    wait_idle();
    chk("mem 10", 8'hA5, mem[19'h10]);
    chk("mem 11", 8'h0C, mem[19'h11]);
    chk("mem 12", 8'hF0, mem[19'h12]);
    chk("mem 13", 8'hFF, mem[19'h13]);
    chk("mem 0F", 8'hFF, mem[19'h0F]);
    done("short program");

    // 258 bytes from offset FE: the first two are zero and must be overwritten
    write_enable_cmd();
    q = {FSD_PAGE_PROGRAM_CMD, 8'h00, 8'h01, 8'hFE};
    for (int k = 0; k < 258; k++)
      q.push_back(k < 2 ? 8'h00 : (8'(k) | 8'h01));
    send(q);
    wait_idle();
    for (int o = 0; o < 256; o++)
    begin
      e = (o < 254) ? (8'(o + 2) | 8'h01) : 8'h01;
      chk("wrapped page", e, mem[19'(256 + o)]);
    end
    chk("next page", 8'hFF, mem[19'h200]);
    done("wrap");

    write_enable_cmd();
    send({FSD_PAGE_PROGRAM_CMD, 8'h00, 8'h02, 8'h00, 8'h00}, 3);
    chk("busy cut program", 1'b0, busy);
    chk("mem cut program", 8'hFF, mem[19'h200]);
    send({FSD_SECTOR_ERASE_CMD, 8'h00, 8'h00});
    chk("busy cut erase", 1'b0, busy);
    chk("latch kept", 1'b1, write_enable_latch);
    done("cut frames");

    mem[19'h7FFFF] = 8'h00;
    for (int p = 1; p < 8; p++)
    begin
      protect = 3'(p);
      send({FSD_PAGE_PROGRAM_CMD, 8'h07, 8'hFF, 8'h00, 8'h00});
      send({FSD_SECTOR_ERASE_CMD, 8'h07, 8'h12, 8'h34});
      send({FSD_WHOLE_ARRAY_ERASE_CMD});
      chk("latch protected", 1'b1, write_enable_latch);
      chk("mem protected", 8'h00, mem[19'h7FFFF]);
      chk("page protected", 8'hFF, mem[19'h7FF00]);
    end
    protect = 3'h0;
    done("protect");

    mem[19'h10000] = 8'h00;
    mem[19'h1FFFF] = 8'h00;
    send({FSD_SECTOR_ERASE_CMD, 8'h01, 8'h23, 8'h45});
    chk("busy erase", 1'b1, busy);
    wait_idle();
    chk("sector low", 8'hFF, mem[19'h10000]);
    chk("sector high", 8'hFF, mem[19'h1FFFF]);
    chk("other sector", 8'hA5, mem[19'h10]);
    write_enable_cmd();
    send({FSD_WHOLE_ARRAY_ERASE_CMD});
    chk("busy array erase", 1'b1, busy);
    wait_idle();
    chk("array low", 8'hFF, mem[19'h10]);
    chk("array high", 8'hFF, mem[19'h7FFFF]);
    done("erase");

    send({FSD_RELEASE_SIGNATURE_CMD, 8'h00, 8'h00, 8'h00}, 16);
    chk("signature", {SIG, SIG}, rx);
    chk("so released", 1'b0, so_oe);
    chk("deep after release", 1'b0, deep);
    done("signature");

    write_enable_cmd();
    send({FSD_PAGE_PROGRAM_CMD, 8'h00, 8'h03, 8'h00, 8'h00});
    send({FSD_DEEP_POWERDOWN_CMD});
    send({FSD_RELEASE_SIGNATURE_CMD, 8'h00, 8'h00, 8'h00}, 16);
    tick(350);
    chk("deep while busy", 1'b0, deep);
    chk("busy undisturbed", 1'b1, busy);
    wait_idle();
    sw_busy = 1'b1;
    tick(2);
    chk("busy follows status write", 1'b1, busy);
    send({FSD_DEEP_POWERDOWN_CMD});
    tick(350);
    chk("deep during status write", 1'b0, deep);
    sw_busy = 1'b0;
    tick(2);
    chk("busy clear", 1'b0, busy);
    done("busy refusals");

    send({FSD_DEEP_POWERDOWN_CMD});
    chk("deep not yet", 1'b0, deep);
    tick(320);
    chk("deep entered", 1'b1, deep);
    send({FSD_WRITE_ENABLE_CMD});
    chk("latch in deep", 1'b0, write_enable_latch);
    send({FSD_RELEASE_SIGNATURE_CMD, 8'h00, 8'h00, 8'h00}, 16);
    chk("signature from deep", {SIG, SIG}, rx);
    chk("release delayed", 1'b1, deep);
    tick(320); // host keeps select high for the release time
    chk("standby again", 1'b0, deep);
    write_enable_cmd();
    done("deep");

    // latch cleared from the status-write side
    wel_clear = 1'b1;
    tick(1);
    wel_clear = 1'b0;
    tick(2);
    chk("latch cleared", 1'b0, write_enable_latch);
    write_enable_cmd();
    send({FSD_DEEP_POWERDOWN_CMD});
    tick(320);
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(2);
    chk("deep after power loss", 1'b0, deep);
    chk("latch after power loss", 1'b0, write_enable_latch);
    done("power loss");
    results();
  end
endmodule // fsd_flash_seq_tb_top
`default_nettype wire
